/* hdl/arith_dec.sv */
`include "arith_dec_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module arith_dec (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   // Bus variant strap
   input  wire logic                       narrow_bus,
   // Prefetch queue side
   input  wire logic                       byte_valid,
   input  wire logic [7:0]                 byte_data,
   output logic                            byte_ready,
   // Execution unit side
   output logic                            dec_valid,
   output arith_dec_pkg::arith_op_t        dec_op,
   output arith_dec_pkg::arith_seg_t       dec_seg,
   output arith_dec_pkg::arith_imm_t       dec_imm,
   output logic                            dec_word,
   output logic                            dec_reg_dest,
   output logic                            dec_mem,
   output logic [5:0]                      dec_cyc_min,
   output logic [5:0]                      dec_cyc_max,
   output logic                            dec_prefix,
   output logic                            dec_unknown
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [0:0] {
      ST_OPCODE,
      ST_MODRM
   } arith_dec_state_t;

   arith_dec_state_t               state_r;
   arith_dec_state_t               state_nxt;
   logic [7:0]                     opc_r;
   logic [7:0]                     opc_nxt;
   arith_dec_pkg::arith_seg_t      seg_r;
   arith_dec_pkg::arith_seg_t      seg_nxt;
   logic                           valid_r;
   logic                           valid_nxt;
   arith_dec_pkg::arith_op_t       op_r;
   arith_dec_pkg::arith_op_t       op_nxt;
   arith_dec_pkg::arith_seg_t      oseg_r;
   arith_dec_pkg::arith_seg_t      oseg_nxt;
   arith_dec_pkg::arith_imm_t      imm_r;
   arith_dec_pkg::arith_imm_t      imm_nxt;
   logic                           word_r;
   logic                           word_nxt;
   logic                           dest_r;
   logic                           dest_nxt;
   logic                           mem_r;
   logic                           mem_nxt;
   logic [5:0]                     cmin_r;
   logic [5:0]                     cmin_nxt;
   logic [5:0]                     cmax_r;
   logic [5:0]                     cmax_nxt;
   logic                           pfx_r;
   logic                           pfx_nxt;
   logic                           unk_r;
   logic                           unk_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic needs_modrm(input logic [7:0] b);
      needs_modrm = (b[7:2] == `AD_TOP_SUM_RM) || (b[7:2] == `AD_TOP_CSUM_RM)
                 || (b[7:2] == `AD_TOP_MINUS_RM) || (b[7:2] == `AD_TOP_BMINUS_RM)
                 || (b[7:2] == `AD_TOP_IMM_GRP) || (b[7:1] == `AD_TOP7_UNARY);
   endfunction : needs_modrm

   function automatic logic [5:0] word_extra(input logic w, input logic m, input logic nb);
      word_extra = (nb && w && m) ? `AD_CYC_NARROW_W : 6'd0;
   endfunction : word_extra

   assign byte_ready = 1'b1;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   always_comb begin
      logic [7:0] b;
      logic       m;
      logic       w;
      logic [5:0] ex;
      b         = byte_data;
      m         = 1'b0;
      w         = 1'b0;
      ex        = 6'd0;
      state_nxt = state_r;
      opc_nxt   = opc_r;
      seg_nxt   = seg_r;
      valid_nxt = 1'b0;
      op_nxt    = op_r;
      oseg_nxt  = oseg_r;
      imm_nxt   = imm_r;
      word_nxt  = word_r;
      dest_nxt  = dest_r;
      mem_nxt   = mem_r;
      cmin_nxt  = cmin_r;
      cmax_nxt  = cmax_r;
      pfx_nxt   = 1'b0;
      unk_nxt   = 1'b0;
      if (byte_valid) begin
         unique case (state_r)
            ST_OPCODE: begin
               op_nxt   = arith_dec_pkg::AD_OP_NONE;
               oseg_nxt = seg_r;
               imm_nxt  = arith_dec_pkg::AD_IMM_NONE;
               word_nxt = b[0];
               dest_nxt = 1'b0;
               mem_nxt  = 1'b0;
               if (b == `AD_PFX_CODE || b == `AD_PFX_STACK
                   || b == `AD_PFX_DATA || b == `AD_PFX_EXTRA) begin
                  unique case (b)
                     `AD_PFX_CODE:  seg_nxt = arith_dec_pkg::AD_SEG_CODE;
                     `AD_PFX_STACK: seg_nxt = arith_dec_pkg::AD_SEG_STACK;
                     `AD_PFX_DATA:  seg_nxt = arith_dec_pkg::AD_SEG_DATA;
                     default:       seg_nxt = arith_dec_pkg::AD_SEG_EXTRA;
                  endcase
                  oseg_nxt  = seg_nxt;
                  valid_nxt = 1'b1;
                  pfx_nxt   = 1'b1;
                  word_nxt  = 1'b0;
                  cmin_nxt  = `AD_CYC_PREFIX;
                  cmax_nxt  = `AD_CYC_PREFIX;
               end else if (needs_modrm(b)) begin
                  opc_nxt   = b;
                  state_nxt = ST_MODRM;
               end else begin
                  valid_nxt = 1'b1;
                  seg_nxt   = arith_dec_pkg::AD_SEG_DEFAULT;
                  oseg_nxt  = arith_dec_pkg::AD_SEG_DEFAULT;
                  cmin_nxt  = b[0] ? `AD_CYC_AC_WORD : `AD_CYC_AC_BYTE;
                  if (b[0]) begin
                     imm_nxt = arith_dec_pkg::AD_IMM_TWO;
                  end else begin
                     imm_nxt = arith_dec_pkg::AD_IMM_ONE;
                  end
                  if (b[7:1] == `AD_TOP7_SUM_AC) begin
                     op_nxt = arith_dec_pkg::AD_OP_SUM;
                  end else if (b[7:1] == `AD_TOP7_CSUM_AC) begin
                     op_nxt = arith_dec_pkg::AD_OP_CSUM;
                  end else if (b[7:1] == `AD_TOP7_MINUS_AC) begin
                     op_nxt = arith_dec_pkg::AD_OP_MINUS;
                  end else if (b[7:1] == `AD_TOP7_BMIN_AC) begin
                     op_nxt = arith_dec_pkg::AD_OP_MINUS_WITH_BORROW;
                  end else begin
                     imm_nxt  = arith_dec_pkg::AD_IMM_NONE;
                     word_nxt = 1'b0;
                     unique case (b)
                        `AD_OP_AAFIX: begin
                           op_nxt   = arith_dec_pkg::AD_OP_ASCII_ADD_FIX;
                           cmin_nxt = `AD_CYC_AAFIX;
                        end
                        `AD_OP_DAFIX: begin
                           op_nxt   = arith_dec_pkg::AD_OP_DECIMAL_ADD_FIX;
                           cmin_nxt = `AD_CYC_DAFIX;
                        end
                        `AD_OP_AMFIX: begin
                           op_nxt   = arith_dec_pkg::AD_OP_ASCII_MINUS_FIX;
                           cmin_nxt = `AD_CYC_AMFIX;
                        end
                        `AD_OP_DMFIX: begin
                           op_nxt   = arith_dec_pkg::AD_OP_DECIMAL_MINUS_FIX;
                           cmin_nxt = `AD_CYC_DMFIX;
                        end
                        default: begin
                           unk_nxt  = 1'b1;
                           cmin_nxt = 6'd0;
                        end
                     endcase
                  end
                  cmax_nxt = cmin_nxt;
               end
            end
            ST_MODRM: begin
               m         = (b[7:6] != `AD_MOD_REG);
               w         = opc_r[0];
               ex        = word_extra(w, m, narrow_bus);
               state_nxt = ST_OPCODE;
               valid_nxt = 1'b1;
               mem_nxt   = m;
               word_nxt  = w;
               oseg_nxt  = m ? seg_r : arith_dec_pkg::AD_SEG_DEFAULT;
               seg_nxt   = arith_dec_pkg::AD_SEG_DEFAULT;
               cmin_nxt  = (m ? `AD_CYC_RM_MEM : `AD_CYC_RM_REG) + ex;
               if (opc_r[7:2] == `AD_TOP_IMM_GRP) begin
                  cmin_nxt = (m ? `AD_CYC_IMM_MEM : `AD_CYC_IMM_REG) + ex;
                  if (!w || opc_r[1]) begin
                     imm_nxt = w ? arith_dec_pkg::AD_IMM_ONE_SEXT
                                 : arith_dec_pkg::AD_IMM_ONE;
                  end else begin
                     imm_nxt = arith_dec_pkg::AD_IMM_TWO;
                  end
                  unique case (b[5:3])
                     `AD_SUB_SUM:    op_nxt = arith_dec_pkg::AD_OP_SUM;
                     `AD_SUB_CSUM:   op_nxt = arith_dec_pkg::AD_OP_CSUM;
                     `AD_SUB_BMINUS: op_nxt = arith_dec_pkg::AD_OP_MINUS_WITH_BORROW;
                     `AD_SUB_MINUS:  op_nxt = arith_dec_pkg::AD_OP_MINUS;
                     default:        unk_nxt = 1'b1;
                  endcase
               end else if (opc_r[7:1] == `AD_TOP7_UNARY) begin
                  if (b[5:3] == `AD_SUB_FLIP) begin
                     op_nxt = arith_dec_pkg::AD_OP_SIGN_FLIP;
                  end else if (b[5:3] == `AD_SUB_PROD) begin
                     op_nxt = arith_dec_pkg::AD_OP_UNSIGNED_PRODUCT;
                     if (m) begin
                        cmin_nxt = (w ? `AD_CYC_PR_MW_MIN : `AD_CYC_PR_MB_MIN) + ex;
                     end else begin
                        cmin_nxt = w ? `AD_CYC_PR_RW_MIN : `AD_CYC_PR_RB_MIN;
                     end
                  end else begin
                     unk_nxt = 1'b1;
                  end
               end else begin
                  dest_nxt = opc_r[1];
                  unique case (opc_r[7:2])
                     `AD_TOP_SUM_RM:    op_nxt = arith_dec_pkg::AD_OP_SUM;
                     `AD_TOP_CSUM_RM:   op_nxt = arith_dec_pkg::AD_OP_CSUM;
                     `AD_TOP_MINUS_RM:  op_nxt = arith_dec_pkg::AD_OP_MINUS;
                     default:           op_nxt = arith_dec_pkg::AD_OP_MINUS_WITH_BORROW;
                  endcase
               end
               cmax_nxt = cmin_nxt;
               if (op_nxt == arith_dec_pkg::AD_OP_UNSIGNED_PRODUCT) begin
                  if (m) begin
                     cmax_nxt = (w ? `AD_CYC_PR_MW_MAX : `AD_CYC_PR_MB_MAX) + ex;
                  end else begin
                     cmax_nxt = w ? `AD_CYC_PR_RW_MAX : `AD_CYC_PR_RB_MAX;
                  end
               end
               if (unk_nxt) begin
                  op_nxt   = arith_dec_pkg::AD_OP_NONE;
                  imm_nxt  = arith_dec_pkg::AD_IMM_NONE;
                  cmin_nxt = 6'd0;
                  cmax_nxt = 6'd0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_OPCODE;
         opc_r   <= 8'h00;
         seg_r   <= arith_dec_pkg::AD_SEG_DEFAULT;
         valid_r <= 1'b0;
         op_r    <= arith_dec_pkg::AD_OP_NONE;
         oseg_r  <= arith_dec_pkg::AD_SEG_DEFAULT;
         imm_r   <= arith_dec_pkg::AD_IMM_NONE;
         word_r  <= 1'b0;
         dest_r  <= 1'b0;
         mem_r   <= 1'b0;
         cmin_r  <= 6'd0;
         cmax_r  <= 6'd0;
         pfx_r   <= 1'b0;
         unk_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         opc_r   <= opc_nxt;
         seg_r   <= seg_nxt;
         valid_r <= valid_nxt;
         op_r    <= op_nxt;
         oseg_r  <= oseg_nxt;
         imm_r   <= imm_nxt;
         word_r  <= word_nxt;
         dest_r  <= dest_nxt;
         mem_r   <= mem_nxt;
         cmin_r  <= cmin_nxt;
         cmax_r  <= cmax_nxt;
         pfx_r   <= pfx_nxt;
         unk_r   <= unk_nxt;
      end
   end

   assign dec_valid    = valid_r;
   assign dec_op       = op_r;
   assign dec_seg      = oseg_r;
   assign dec_imm      = imm_r;
   assign dec_word     = word_r;
   assign dec_reg_dest = dest_r;
   assign dec_mem      = mem_r;
   assign dec_cyc_min  = cmin_r;
   assign dec_cyc_max  = cmax_r;
   assign dec_prefix   = pfx_r;
   assign dec_unknown  = unk_r;

endmodule : arith_dec

`default_nettype wire

/* hdl/arith_dec_consts.svh */
`ifndef ARITH_DEC_CONSTS_SVH
`define ARITH_DEC_CONSTS_SVH

// ----------------------------------------
// Prefix bytes
// ----------------------------------------
`define AD_PFX_CODE      8'h2e
`define AD_PFX_STACK     8'h36
`define AD_PFX_DATA      8'h3e
`define AD_PFX_EXTRA     8'h26

// ----------------------------------------
// Single-byte adjusts
// ----------------------------------------
`define AD_OP_AAFIX      8'h37
`define AD_OP_DAFIX      8'h27
`define AD_OP_AMFIX      8'h3f
`define AD_OP_DMFIX      8'h2f

// ----------------------------------------
// Opcode patterns, upper bits
// ----------------------------------------
`define AD_TOP_SUM_RM    6'h00
`define AD_TOP_CSUM_RM   6'h04
`define AD_TOP_MINUS_RM  6'h0a
`define AD_TOP_BMINUS_RM 6'h06
`define AD_TOP_IMM_GRP   6'h20
`define AD_TOP7_SUM_AC   7'h02
`define AD_TOP7_CSUM_AC  7'h0a
`define AD_TOP7_MINUS_AC 7'h16
`define AD_TOP7_BMIN_AC  7'h0e
`define AD_TOP7_UNARY    7'h7b

// ----------------------------------------
// ModRM sub-opcodes
// ----------------------------------------
`define AD_SUB_SUM       3'h0
`define AD_SUB_CSUM      3'h2
`define AD_SUB_BMINUS    3'h3
`define AD_SUB_MINUS     3'h5
`define AD_SUB_FLIP      3'h3
`define AD_SUB_PROD      3'h4
`define AD_MOD_REG       2'h3

// ----------------------------------------
// Clock counts: minimums, product maximums, narrow-bus word extra
// ----------------------------------------
`define AD_CYC_PREFIX    6'd2
`define AD_CYC_RM_REG    6'd3
`define AD_CYC_RM_MEM    6'd10
`define AD_CYC_IMM_REG   6'd4
`define AD_CYC_IMM_MEM   6'd16
`define AD_CYC_AC_BYTE   6'd3
`define AD_CYC_AC_WORD   6'd4
`define AD_CYC_AAFIX     6'd8
`define AD_CYC_DAFIX     6'd4
`define AD_CYC_AMFIX     6'd7
`define AD_CYC_DMFIX     6'd4
`define AD_CYC_PR_RB_MIN 6'd26
`define AD_CYC_PR_RB_MAX 6'd28
`define AD_CYC_PR_RW_MIN 6'd35
`define AD_CYC_PR_RW_MAX 6'd37
`define AD_CYC_PR_MB_MIN 6'd32
`define AD_CYC_PR_MB_MAX 6'd34
`define AD_CYC_PR_MW_MIN 6'd41
`define AD_CYC_PR_MW_MAX 6'd43
`define AD_CYC_NARROW_W  6'd4

`endif

/* hdl/arith_dec_pkg.sv */
package arith_dec_pkg;

   typedef enum logic [3:0] {
      AD_OP_NONE,
      AD_OP_SUM,
      AD_OP_CSUM,
      AD_OP_MINUS,
      AD_OP_MINUS_WITH_BORROW,
      AD_OP_SIGN_FLIP,
      AD_OP_ASCII_ADD_FIX,
      AD_OP_DECIMAL_ADD_FIX,
      AD_OP_ASCII_MINUS_FIX,
      AD_OP_DECIMAL_MINUS_FIX,
      AD_OP_UNSIGNED_PRODUCT
   } arith_op_t;

   typedef enum logic [2:0] {
      AD_SEG_DEFAULT,
      AD_SEG_CODE,
      AD_SEG_STACK,
      AD_SEG_DATA,
      AD_SEG_EXTRA
   } arith_seg_t;

   typedef enum logic [1:0] {
      AD_IMM_NONE,
      AD_IMM_ONE,
      AD_IMM_ONE_SEXT,
      AD_IMM_TWO
   } arith_imm_t;

endpackage : arith_dec_pkg

/* verif/arith_dec_props.sv */
`timescale 1ns/10ps
`default_nettype none

module arith_dec_props (
   // Clock and reset
   input wire logic                      clock,
   input wire logic                      arst_n,
   // Queue side
   input wire logic                      narrow_bus,
   input wire logic                      byte_valid,
   input wire logic [7:0]                byte_data,
   input wire logic                      byte_ready,
   // Execution unit side
   input wire logic                      dec_valid,
   input var  arith_dec_pkg::arith_op_t  dec_op,
   input var  arith_dec_pkg::arith_seg_t dec_seg,
   input var  arith_dec_pkg::arith_imm_t dec_imm,
   input wire logic                      dec_word,
   input wire logic                      dec_reg_dest,
   input wire logic                      dec_mem,
   input wire logic [5:0]                dec_cyc_min,
   input wire logic [5:0]                dec_cyc_max,
   input wire logic                      dec_prefix,
   input wire logic                      dec_unknown
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic arith_dec_pkg::arith_seg_t seg_of(input logic [7:0] b);
      case (b)
         8'h2e: return arith_dec_pkg::AD_SEG_CODE;
         8'h36: return arith_dec_pkg::AD_SEG_STACK;
         8'h3e: return arith_dec_pkg::AD_SEG_DATA;
         8'h26: return arith_dec_pkg::AD_SEG_EXTRA;
         default: return arith_dec_pkg::AD_SEG_DEFAULT;
      endcase
   endfunction : seg_of

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_ready_high: assert property (byte_ready)
      else $error("byte_ready low");
   chk_answer_cause: assert property (dec_valid |-> $past(byte_valid))
      else $error("answer without a taken byte");
   chk_prefix_map: assert property (dec_valid && dec_prefix |-> dec_cyc_min == 6'd2
      && dec_cyc_max == 6'd2 && dec_seg != arith_dec_pkg::AD_SEG_DEFAULT
      && dec_seg == seg_of($past(byte_data))) else $error("prefix decode wrong");
   chk_aafix_cost: assert property (dec_valid && dec_op == arith_dec_pkg::AD_OP_ASCII_ADD_FIX
      |-> $past(byte_data) == 8'h37 && dec_cyc_min == 6'd8) else $error("ascii add fix wrong");
   chk_dafix_cost: assert property (dec_valid && dec_op == arith_dec_pkg::AD_OP_DECIMAL_ADD_FIX
      |-> $past(byte_data) == 8'h27 && dec_cyc_min == 6'd4) else $error("decimal add fix wrong");
   chk_amfix_cost: assert property (dec_valid && dec_op == arith_dec_pkg::AD_OP_ASCII_MINUS_FIX
      |-> $past(byte_data) == 8'h3f && dec_cyc_min == 6'd7) else $error("ascii minus fix wrong");
   chk_dmfix_cost: assert property (dec_valid && dec_op == arith_dec_pkg::AD_OP_DECIMAL_MINUS_FIX
      |-> $past(byte_data) == 8'h2f && dec_cyc_min == 6'd4) else $error("decimal minus fix wrong");
   chk_flip_cost: assert property (dec_valid && dec_op == arith_dec_pkg::AD_OP_SIGN_FLIP
      |-> dec_cyc_min == (dec_mem ? 6'd10 : 6'd3) + ((dec_mem && dec_word && $past(narrow_bus))
      ? 6'd4 : 6'd0)) else $error("sign flip cost wrong");
   chk_prod_range: assert property (dec_valid && dec_op == arith_dec_pkg::AD_OP_UNSIGNED_PRODUCT
      |-> dec_cyc_max == dec_cyc_min + 6'd2 && dec_cyc_min == (dec_word ? (dec_mem ? 6'd41 : 6'd35)
      : (dec_mem ? 6'd32 : 6'd26)) + ((dec_mem && dec_word && $past(narrow_bus)) ? 6'd4 : 6'd0))
      else $error("product range wrong");
   chk_seg_reg: assert property (dec_valid && !dec_mem && !dec_prefix |-> dec_seg == arith_dec_pkg::AD_SEG_DEFAULT)
      else $error("segment on register operand");
   chk_imm_sext: assert property (dec_valid && dec_imm == arith_dec_pkg::AD_IMM_ONE_SEXT
      |-> dec_word && $past(byte_data, 2) == 8'h83) else $error("sign extend wrong");

   // ----------------------------------------
   // Covers
   // ----------------------------------------
   cov_prefix: cover property (dec_valid && dec_prefix);
   cov_product: cover property (dec_valid && dec_op == arith_dec_pkg::AD_OP_UNSIGNED_PRODUCT);
   cov_narrow: cover property (dec_valid && dec_mem && dec_word && $past(narrow_bus));
endmodule : arith_dec_props

`default_nettype wire

/* verif/arith_dec_feeder.sv */
`timescale 1ns/10ps
`default_nettype none

module arith_dec_feeder (
   // Clock
   input  wire logic       clock,
   // Byte offer
   output var logic        byte_valid,
   output var logic [7:0]  byte_data
);
   initial begin
      byte_valid = 1'b0;
      byte_data  = 8'h00;
   end

   // Offer one or two bytes back to back, then release
   task automatic send(input int n, input logic [7:0] b0, input logic [7:0] b1);
      @(posedge clock);
      #1;
      byte_valid = 1'b1;
      byte_data  = b0;
      @(posedge clock);
      if (n > 1) begin
         #1;
         byte_data = b1;
         @(posedge clock);
      end
      #1;
      byte_valid = 1'b0;
      byte_data  = ~byte_data;
   endtask : send
endmodule : arith_dec_feeder

`default_nettype wire

/* verif/arith_dec_test.sv */
`timescale 1ns/10ps
`default_nettype none

module arith_dec_test;
   // ----------------------------------------
   // Signals and tables
   // ----------------------------------------
   logic                      clock = 1'b0;
   logic                      arst_n = 1'b0;
   logic                      narrow_bus = 1'b0;
   logic                      byte_valid, byte_ready, dec_valid, dec_word;
   logic [7:0]                byte_data;
   arith_dec_pkg::arith_op_t  dec_op;
   arith_dec_pkg::arith_seg_t dec_seg;
   arith_dec_pkg::arith_imm_t dec_imm;
   logic                      dec_reg_dest, dec_mem, dec_prefix, dec_unknown;
   logic [5:0]                dec_cyc_min, dec_cyc_max;
   int                        num_errors = 0;
   int                        samples_checked = 0;
   int                        cycles = 0;
   localparam logic [7:0] RM_TOP [4] = '{8'h00, 8'h10, 8'h28, 8'h18};
   localparam logic [7:0] AC_TOP [4] = '{8'h04, 8'h14, 8'h2c, 8'h1c};
   localparam logic [2:0] IM_SUB [4] = '{3'h0, 3'h2, 3'h5, 3'h3};
   localparam arith_dec_pkg::arith_op_t RM_OP [4] = '{arith_dec_pkg::AD_OP_SUM,
      arith_dec_pkg::AD_OP_CSUM, arith_dec_pkg::AD_OP_MINUS, arith_dec_pkg::AD_OP_MINUS_WITH_BORROW};

   arith_dec u_arith_dec (.clock(clock), .arst_n(arst_n), .narrow_bus(narrow_bus),
      .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
      .dec_valid(dec_valid), .dec_op(dec_op), .dec_seg(dec_seg), .dec_imm(dec_imm),
      .dec_word(dec_word), .dec_reg_dest(dec_reg_dest), .dec_mem(dec_mem),
      .dec_cyc_min(dec_cyc_min), .dec_cyc_max(dec_cyc_max), .dec_prefix(dec_prefix),
      .dec_unknown(dec_unknown));
   arith_dec_feeder u_arith_dec_feeder (.clock(clock), .byte_valid(byte_valid),
      .byte_data(byte_data));

   initial begin
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Compare tasks
   // ----------------------------------------
   task automatic chk_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_flag

   task automatic chk_field(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_field

   // Word, register-destination and memory flags packed as wrm
   task automatic chk_dec(input arith_dec_pkg::arith_op_t op, input arith_dec_pkg::arith_seg_t sg,
      input arith_dec_pkg::arith_imm_t im, input logic [2:0] wrm, input logic [5:0] mn,
      input logic [5:0] mx);
      chk_flag(dec_valid, 1'b1);
      chk_flag(dec_prefix | dec_unknown, 1'b0);
      chk_field(8'(dec_op), 8'(op));
      chk_field(8'(dec_seg), 8'(sg));
      chk_field(8'(dec_imm), 8'(im));
      chk_field({5'h00, dec_word, dec_reg_dest, dec_mem}, {5'h00, wrm});
      chk_field({2'h0, dec_cyc_min}, {2'h0, mn});
      chk_field({2'h0, dec_cyc_max}, {2'h0, mx});
   endtask : chk_dec

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk_field({6'h00, byte_ready, dec_valid}, 8'h02);
      chk_field(8'(dec_op), 8'(arith_dec_pkg::AD_OP_NONE));
      chk_field({2'h0, dec_cyc_min}, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_prefix();
      logic [7:0] pfx [4] = '{8'h2e, 8'h36, 8'h3e, 8'h26};
      arith_dec_pkg::arith_seg_t sg [4] = '{arith_dec_pkg::AD_SEG_CODE,
         arith_dec_pkg::AD_SEG_STACK, arith_dec_pkg::AD_SEG_DATA, arith_dec_pkg::AD_SEG_EXTRA};
      for (int i = 0; i < 4; i++) begin
         u_arith_dec_feeder.send(1, pfx[i], 8'h00);
         chk_flag(dec_valid & dec_prefix, 1'b1);
         chk_field(8'(dec_seg), 8'(sg[i]));
         chk_field({2'h0, dec_cyc_min}, 8'h02);
         u_arith_dec_feeder.send(2, 8'h01, 8'h86);
         chk_dec(arith_dec_pkg::AD_OP_SUM, sg[i], arith_dec_pkg::AD_IMM_NONE, 3'b101, 10, 10);
         u_arith_dec_feeder.send(2, 8'h03, 8'h86);
         chk_dec(arith_dec_pkg::AD_OP_SUM, arith_dec_pkg::AD_SEG_DEFAULT,
            arith_dec_pkg::AD_IMM_NONE, 3'b111, 10, 10);
      end
      $display("test prefix done");
   endtask : t_prefix

   task automatic t_adjust();
      logic [7:0] code [4] = '{8'h37, 8'h27, 8'h3f, 8'h2f};
      logic [5:0] cyc [4] = '{6'd8, 6'd4, 6'd7, 6'd4};
      arith_dec_pkg::arith_op_t op [4] = '{arith_dec_pkg::AD_OP_ASCII_ADD_FIX,
         arith_dec_pkg::AD_OP_DECIMAL_ADD_FIX, arith_dec_pkg::AD_OP_ASCII_MINUS_FIX,
         arith_dec_pkg::AD_OP_DECIMAL_MINUS_FIX};
      for (int i = 0; i < 4; i++) begin
         u_arith_dec_feeder.send(1, code[i], 8'h00);
         chk_dec(op[i], arith_dec_pkg::AD_SEG_DEFAULT, arith_dec_pkg::AD_IMM_NONE, 3'b000,
            cyc[i], cyc[i]);
      end
      $display("test adjust done");
   endtask : t_adjust

   task automatic t_accum();
      for (int i = 0; i < 8; i++) begin
         u_arith_dec_feeder.send(1, AC_TOP[i/2] | 8'(i[0]), 8'h00);
         chk_dec(RM_OP[i/2], arith_dec_pkg::AD_SEG_DEFAULT, i[0] ? arith_dec_pkg::AD_IMM_TWO :
            arith_dec_pkg::AD_IMM_ONE, {i[0], 2'b00}, i[0] ? 6'd4 : 6'd3,
            i[0] ? 6'd4 : 6'd3);
      end
      $display("test accumulator done");
   endtask : t_accum

   task automatic t_regmem();
      for (int i = 0; i < 32; i++) begin
         u_arith_dec_feeder.send(2, RM_TOP[i/8] | 8'(i[2:1]), i[0] ? 8'h86 : 8'hc0);
         chk_dec(RM_OP[i/8], arith_dec_pkg::AD_SEG_DEFAULT, arith_dec_pkg::AD_IMM_NONE,
            {i[1], i[2], i[0]}, i[0] ? 6'd10 : 6'd3, i[0] ? 6'd10 : 6'd3);
      end
      $display("test register memory done");
   endtask : t_regmem

   task automatic t_immgrp();
      arith_dec_pkg::arith_imm_t im;
      for (int i = 0; i < 32; i++) begin
         im = !i[1] ? arith_dec_pkg::AD_IMM_ONE : i[2] ? arith_dec_pkg::AD_IMM_ONE_SEXT :
            arith_dec_pkg::AD_IMM_TWO;
         u_arith_dec_feeder.send(2, 8'h80 | 8'(i[2:1]), {i[0] ? 2'b10 : 2'b11, IM_SUB[i/8], 3'b110});
         chk_dec(RM_OP[i/8], arith_dec_pkg::AD_SEG_DEFAULT, im, {i[1], 1'b0, i[0]},
            i[0] ? 6'd16 : 6'd4, i[0] ? 6'd16 : 6'd4);
      end
      $display("test immediate group done");
   endtask : t_immgrp

   task automatic t_unary();
      logic [5:0] mn;
      for (int i = 0; i < 8; i++) begin
         mn = i[2] ? (i[1] ? (i[0] ? 6'd41 : 6'd35) : (i[0] ? 6'd32 : 6'd26)) : (i[0] ? 6'd10 : 6'd3);
         u_arith_dec_feeder.send(2, 8'hf6 | 8'(i[1]), {i[0] ? 2'b10 : 2'b11, i[2] ? 3'h4 : 3'h3, 3'b110});
         chk_dec(i[2] ? arith_dec_pkg::AD_OP_UNSIGNED_PRODUCT : arith_dec_pkg::AD_OP_SIGN_FLIP,
            arith_dec_pkg::AD_SEG_DEFAULT, arith_dec_pkg::AD_IMM_NONE, {i[1], 1'b0, i[0]},
            mn, i[2] ? mn + 6'd2 : mn);
      end
      $display("test unary done");
   endtask : t_unary

   task automatic t_narrow();
      narrow_bus = 1'b1;
      u_arith_dec_feeder.send(2, 8'h01, 8'h86);
      chk_dec(arith_dec_pkg::AD_OP_SUM, arith_dec_pkg::AD_SEG_DEFAULT,
         arith_dec_pkg::AD_IMM_NONE, 3'b101, 14, 14);
      u_arith_dec_feeder.send(2, 8'h00, 8'h86);
      chk_dec(arith_dec_pkg::AD_OP_SUM, arith_dec_pkg::AD_SEG_DEFAULT,
         arith_dec_pkg::AD_IMM_NONE, 3'b001, 10, 10);
      u_arith_dec_feeder.send(2, 8'hf7, 8'ha6);
      chk_dec(arith_dec_pkg::AD_OP_UNSIGNED_PRODUCT, arith_dec_pkg::AD_SEG_DEFAULT,
         arith_dec_pkg::AD_IMM_NONE, 3'b101, 45, 47);
      narrow_bus = 1'b0;
      u_arith_dec_feeder.send(1, 8'h90, 8'h00);
      chk_flag(dec_valid & dec_unknown, 1'b1);
      chk_field({2'h0, dec_cyc_max}, 8'h00);
      $display("test narrow and unknown done");
   endtask : t_narrow

   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   initial begin
      repeat (20) @(posedge clock);
      #1;
      t_reset();
      arst_n = 1'b1;
      t_prefix();
      t_adjust();
      t_accum();
      t_regmem();
      t_immgrp();
      t_unary();
      t_narrow();
      end_sim();
   end
endmodule : arith_dec_test

bind arith_dec arith_dec_props u_arith_dec_props (.clock(clock), .arst_n(arst_n),
   .narrow_bus(narrow_bus), .byte_valid(byte_valid), .byte_data(byte_data),
   .byte_ready(byte_ready), .dec_valid(dec_valid), .dec_op(dec_op), .dec_seg(dec_seg),
   .dec_imm(dec_imm), .dec_word(dec_word), .dec_reg_dest(dec_reg_dest), .dec_mem(dec_mem),
   .dec_cyc_min(dec_cyc_min), .dec_cyc_max(dec_cyc_max), .dec_prefix(dec_prefix),
   .dec_unknown(dec_unknown));

`default_nettype wire
